//--- jls_link_sync.sv
// Link sync input control: source select, CGS/ILAS sequencing, SYSREF receiver control
// Summary of operation
// - Sync input active low, 8B/10B, select zero.
// - 64B/66B modes ignore sync request entirely.
// - Low request starts code group synchronisation.
// - Release to high starts lane alignment sequence.
// - SYSREF input serves as alignment reference.
// - Receiver enable bit; clear powers SYSREF down.
// - Termination bit: 0 AC 100 ohm, 1 DC 50.
// - Timestamp input selectable as alternate sync source.
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module jls_link_sync
	import jls_pkg::*;
(
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	// Wishbone classic slave
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [3:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	// Link sync request inputs
	input wire logic SINGLE_ENDED_SYNC_REQUEST_B_IN,
	input wire logic TIMESTAMP_DIFFERENTIAL_INPUT_IN,
	// SYSREF input and receiver control
	input wire logic SYSREF_IN,
	output logic SYSREF_RECEIVER_ENABLE_OUT,
	output logic SYSREF_DC_TERMINATION_SELECT_OUT,
	// Lane sequencing commands
	output logic CGS_START_OUT,
	output logic ILAS_START_OUT,
	output logic CGS_ACTIVE_OUT,
	output logic SYSREF_REF_OUT
);
	// Hazards and limits worth knowing:
	// both request sources share one synchroniser, so switching the source
	// while the two pins differ looks like an edge and may restart CGS;
	// ILAS is a single-cycle marker here, the lane logic stretches it;
	// register reads capture data on the take edge, writes land on the
	// edge that sees ack high, so a read right after a write sees it;
	// 64B/66B mode forces DATA and ignores both request pins;
	// the SYSREF reference is forced low from one cycle after the receiver turns off,
	// so lane logic never aligns to a powered-down input;
	// the request level, not only its edge, starts CGS from IDLE or DATA,
	// so a request held through a mode change is still honoured.

	// Whole state of the block
	typedef struct packed {
		logic [JLS_CTRL_WIDTH-1:0] ctrl; // Control word
		jls_state_type link_state; // Link sequencing state
		logic [31:0] rdata; // Registered read data
		logic ack; // Registered bus acknowledge
		logic cgs_start; // One-cycle CGS start pulse
		logic ilas_start; // One-cycle ILAS start pulse
		logic sysref_ref; // Gated SYSREF reference
		logic cgs_active; // Registered CGS state decode
	} jls_top_type;

	jls_top_type st; // Registered state
	jls_top_type next_st; // Next state
	logic sync_src_b; // Selected raw request, active low
	logic use_sync; // Request honoured in this mode
	logic bus_req; // Bus request, first cycle only
	logic bus_commit; // Write commit, acknowledge edge

	// Synchronised levels and edges from the input stage
	jls_sync_if sync_bus ();

	// Pick request source; the switch sits before the synchroniser
	// so the chosen pin is still synchronised before any edge is used
	assign sync_src_b = (st.ctrl[JLS_CTRL_SYNC_SEL_BIT] == JLS_SRC_TIMESTAMP) ?
		TIMESTAMP_DIFFERENTIAL_INPUT_IN :
		SINGLE_ENDED_SYNC_REQUEST_B_IN;

	// Synchronisers and edge detectors
	jls_input_sync u_input_sync (
		.clk_in(CLK_IN),
		.rst_b_in(RST_B_IN),
		.sync_raw_b_in(sync_src_b),
		.sysref_raw_in(SYSREF_IN),
		.sync_out(sync_bus)
	);

	// Only 8B/10B honours the request
	assign use_sync = ~st.ctrl[JLS_CTRL_MODE_64B66B_BIT];
	// Take only while ack is low, so each access answers once
	assign bus_req = WB_CYC_IN & WB_STB_IN & ~st.ack;
	// The master still holds the write while ack stands; commit then
	assign bus_commit = WB_CYC_IN & WB_STB_IN & WB_WE_IN & st.ack;

	// Field merge for byte-lane writes of the control word
	function automatic logic [JLS_CTRL_WIDTH-1:0] jls_merge(
		input logic [JLS_CTRL_WIDTH-1:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0] sel
	);
		jls_merge = sel[0] ? wdata[JLS_CTRL_WIDTH-1:0] : old_val;
	endfunction

	// Status word: one-hot state, synchronised request level,
	// gated SYSREF reference
	function automatic logic [31:0] jls_status_word(
		input jls_state_type state,
		input logic sync_level,
		input logic sysref_ref
	);
		logic [31:0] word; // Assembled status
		// Unused bits read zero
		word = '0;
		word[JLS_STAT_STATE_LSB +: $bits(jls_state_type)] = state;
		word[JLS_STAT_SYNC_LVL_BIT] = sync_level;
		word[JLS_STAT_SYSREF_BIT] = sysref_ref;
		jls_status_word = word;
	endfunction

	// Next-state logic
	always_comb begin
		// Defaults: hold state, pulses low, ack follows the take
		next_st = st;
		next_st.ack = bus_req;
		next_st.cgs_start = 1'b0;
		next_st.ilas_start = 1'b0;
		// SYSREF reference gated by receiver enable
		next_st.sysref_ref = sync_bus.sysref_level & st.ctrl[JLS_CTRL_SYSREF_EN_BIT];
		// Register access: read data captured on the take edge
		if (bus_req) begin
			next_st.rdata = '0;
			unique case (WB_ADR_IN)
				JLS_CTRL_OFFSET: begin
					// Control word reads back as stored
					next_st.rdata[JLS_CTRL_WIDTH-1:0] = st.ctrl;
				end
				JLS_STATUS_OFFSET: begin
					// Read-only status; writes here are dropped
					next_st.rdata = jls_status_word(st.link_state, sync_bus.sync_level,
						st.sysref_ref);
				end
				default: begin
					// Unmapped: reads zero, writes dropped
					next_st.rdata = '0;
				end
			endcase
		end

		// Control write lands on the edge that sees ack high
		if (bus_commit && (WB_ADR_IN == JLS_CTRL_OFFSET)) begin
			// Byte lane 0 carries every control bit
			next_st.ctrl = jls_merge(st.ctrl, WB_DAT_IN, WB_SEL_IN);
		end
		// Link sequencing
		if (!use_sync) begin
			// 64B/66B: come up with no handshake
			next_st.link_state = JLS_ST_DATA;
		end else begin
			unique case (st.link_state)
				JLS_ST_IDLE, JLS_ST_DATA: begin
					// Low level, not only a fresh edge, so a request held
					// across a mode change is still honoured
					if (!sync_bus.sync_level) begin
						next_st.link_state = JLS_ST_CGS;
						next_st.cgs_start = 1'b1;
					end
				end
				JLS_ST_CGS: begin
					// Wait for the synchronised release edge
					if (sync_bus.sync_rise) begin
						next_st.link_state = JLS_ST_ILAS;
						next_st.ilas_start = 1'b1;
					end
				end
				JLS_ST_ILAS: begin
					// Renewed request restarts CGS, else proceed to data
					if (!sync_bus.sync_level) begin
						next_st.link_state = JLS_ST_CGS;
						next_st.cgs_start = 1'b1;
					end else begin
						// Alignment marker sent, link carries data
						next_st.link_state = JLS_ST_DATA;
					end
				end
				default: begin
					// Illegal one-hot code: fall back to idle
					next_st.link_state = JLS_ST_IDLE;
				end
			endcase
		end
		// Registered decode keeps the active flag glitch free
		next_st.cgs_active = (next_st.link_state == JLS_ST_CGS);
	end

	// State register
	// Synchronous reset, active low; every field takes a constant
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			// Known idle values
			st <= '{ctrl: JLS_CTRL_RESET, link_state: JLS_ST_IDLE, rdata: 32'h0,
				ack: 1'b0, cgs_start: 1'b0, ilas_start: 1'b0, sysref_ref: 1'b0,
				cgs_active: 1'b0};
		end else begin
			// Advance
			st <= next_st;
		end
	end

	// Outputs straight from flops
	// Bus answer
	assign WB_DAT_OUT = st.rdata;
	assign WB_ACK_OUT = st.ack;

	// SYSREF pad controls
	assign SYSREF_RECEIVER_ENABLE_OUT = st.ctrl[JLS_CTRL_SYSREF_EN_BIT];
	assign SYSREF_DC_TERMINATION_SELECT_OUT = st.ctrl[JLS_CTRL_SYSREF_TERM_BIT];

	// Lane sequencing commands
	assign CGS_START_OUT = st.cgs_start;
	assign ILAS_START_OUT = st.ilas_start;
	assign CGS_ACTIVE_OUT = st.cgs_active;

	// Alignment reference
	assign SYSREF_REF_OUT = st.sysref_ref;
endmodule : jls_link_sync

//--- jls_pkg.sv
// Package with register map, field layout and state codes of the link sync input block
package jls_pkg;
	// Register byte offsets
	localparam logic [3:0] JLS_CTRL_OFFSET = 4'h0;
	localparam logic [3:0] JLS_STATUS_OFFSET = 4'h4;
	// Control register fields
	localparam int JLS_CTRL_MODE_64B66B_BIT = 0;
	localparam int JLS_CTRL_SYNC_SEL_BIT = 1;
	localparam int JLS_CTRL_SYSREF_EN_BIT = 2;
	localparam int JLS_CTRL_SYSREF_TERM_BIT = 3;
	localparam int JLS_CTRL_WIDTH = 4;
	// Control reset value: 8B/10B, single-ended source, receiver off, AC termination
	localparam logic [3:0] JLS_CTRL_RESET = 4'h0;
	// Status register fields
	localparam int JLS_STAT_STATE_LSB = 0;
	localparam int JLS_STAT_SYNC_LVL_BIT = 4;
	localparam int JLS_STAT_SYSREF_BIT = 5;
	// Sync source codes
	localparam logic JLS_SRC_SINGLE_ENDED = 1'b0;
	localparam logic JLS_SRC_TIMESTAMP = 1'b1;
	// Link sequencing states, one-hot
	typedef enum logic [3:0] {
		JLS_ST_IDLE = 4'h1,
		JLS_ST_CGS = 4'h2,
		JLS_ST_ILAS = 4'h4,
		JLS_ST_DATA = 4'h8
	} jls_state_type;
	// Registered sync levels held inside the input synchroniser
	typedef struct packed {
		logic sync_meta;
		logic sync_sync;
		logic sync_prev;
		logic sysref_meta;
		logic sysref_sync;
	} jls_sync_type;
endpackage : jls_pkg

//--- jls_sync_if.sv
// Interface carrying synchronised sync request and SYSREF levels
`timescale 1ns/1ps
interface jls_sync_if;
	logic sync_level; // Synchronised active-low request level
	logic sync_fall; // One-cycle pulse, request asserted
	logic sync_rise; // One-cycle pulse, request released
	logic sysref_level; // Synchronised SYSREF level
	modport producer (output sync_level, sync_fall, sync_rise, sysref_level);
	modport consumer (input sync_level, sync_fall, sync_rise, sysref_level);
endinterface : jls_sync_if

//--- jls_input_sync.sv
// Two-flop synchronisers for the sync request and SYSREF, edge detection for the sync request only
`timescale 1ns/1ps
module jls_input_sync
	import jls_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Raw inputs
	input wire logic sync_raw_b_in,
	input wire logic sysref_raw_in,
	// Synchronised outputs
	jls_sync_if.producer sync_out
);
	jls_sync_type st; // All state
	jls_sync_type next_st; // Next state

	// Shift raw levels through two flops; edges from synchronised flops only
	always_comb begin
		next_st = st;
		next_st.sync_meta = sync_raw_b_in;
		next_st.sync_sync = st.sync_meta;
		next_st.sync_prev = st.sync_sync;
		next_st.sysref_meta = sysref_raw_in;
		next_st.sysref_sync = st.sysref_meta;
	end

	// Register state; idle request level is high
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			st <= '{sync_meta: 1'b1, sync_sync: 1'b1, sync_prev: 1'b1,
				sysref_meta: 1'b0, sysref_sync: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// Outputs to consumer
	assign sync_out.sync_level = st.sync_sync;
	assign sync_out.sync_fall = st.sync_prev & ~st.sync_sync;
	assign sync_out.sync_rise = ~st.sync_prev & st.sync_sync;
	assign sync_out.sysref_level = st.sysref_sync;
endmodule : jls_input_sync

//--- jls_link_sync_props.sv
// Port checks for the link sync block
`timescale 1ns/1ps
module jls_link_sync_props (
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [3:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic WB_ACK_OUT,
	input wire logic SINGLE_ENDED_SYNC_REQUEST_B_IN,
	input wire logic TIMESTAMP_DIFFERENTIAL_INPUT_IN,
	input wire logic SYSREF_RECEIVER_ENABLE_OUT,
	input wire logic SYSREF_DC_TERMINATION_SELECT_OUT,
	input wire logic CGS_START_OUT,
	input wire logic ILAS_START_OUT,
	input wire logic CGS_ACTIVE_OUT,
	input wire logic SYSREF_REF_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	// Acknowledged control write
	wire wr = WB_ACK_OUT && WB_WE_IN && WB_ADR_IN == 4'h0 && WB_SEL_IN[0];
	// Either request pin low
	wire lo = !SINGLE_ENDED_SYNC_REQUEST_B_IN || !TIMESTAMP_DIFFERENTIAL_INPUT_IN;
	property p_ack; WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT ##1 !WB_ACK_OUT; endproperty
	a_ack: assert property (p_ack) else $error("ack timing");
	property p_map; WB_ACK_OUT && !(WB_ADR_IN inside {4'h0, 4'h4}) |-> !WB_DAT_OUT; endproperty
	a_map: assert property (p_map) else $error("unmapped data");
	property p_en; wr |=> SYSREF_RECEIVER_ENABLE_OUT == $past(WB_DAT_IN[2]); endproperty
	a_en: assert property (p_en) else $error("enable bit");
	property p_term; wr |=> SYSREF_DC_TERMINATION_SELECT_OUT == $past(WB_DAT_IN[3]); endproperty
	a_term: assert property (p_term) else $error("termination bit");
	property p_ref; !SYSREF_RECEIVER_ENABLE_OUT [*3] |-> !SYSREF_REF_OUT; endproperty
	a_ref: assert property (p_ref) else $error("ref while off");
	property p_cause; $rose(CGS_START_OUT) |-> $past(lo, 2) || $past(lo, 3) || $past(lo, 4); endproperty
	a_cause: assert property (p_cause) else $error("start without request");
	property p_cgs; CGS_START_OUT |-> CGS_ACTIVE_OUT ##1 !CGS_START_OUT; endproperty
	a_cgs: assert property (p_cgs) else $error("cgs pulse");
	property p_ilas; ILAS_START_OUT |-> !CGS_ACTIVE_OUT && $past(CGS_ACTIVE_OUT) ##1 !ILAS_START_OUT; endproperty
	a_ilas: assert property (p_ilas) else $error("ilas pulse");
	c_cgs: cover property (CGS_START_OUT);
	c_ilas: cover property (ILAS_START_OUT);
	c_ref: cover property (SYSREF_REF_OUT);
endmodule // jls_link_sync_props
bind jls_link_sync jls_link_sync_props u_props (.*);

//--- jls_rx_model.sv
// Far-end receiver model driving the sync request
`timescale 1ns/1ps
module jls_rx_model (
	// Clock and resync wish
	input wire logic clk_in,
	input wire logic resync_in,
	// Active-low request
	output logic sync_req_b_out
);
	// Low while resync wanted, released high after
	always_ff @(posedge clk_in) begin
		sync_req_b_out <= !resync_in;
	end
endmodule // jls_rx_model

//--- tb_top.sv
// Bench for the link sync block
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, rst_b = 0, cyc = 0, we = 0, ack, rs = 0, ts = 1, sr = 0, se_b;
	logic [3:0] adr = 0, sel = 0;
	logic [31:0] wd = 0, rd, v;
	logic [63:0] q[$]; // Expected mask and word
	int fails = 0, n_checks = 0, ticks = 0;
	int n_cgs = 0, n_ilas = 0; // Start pulses seen
	logic en_o, term_o, cgs_s, ilas_s, cgs_a, ref_o; // Watched outputs
	always #2.5 clk = ~clk;
	jls_rx_model u_rx (.clk_in(clk), .resync_in(rs), .sync_req_b_out(se_b));
	jls_link_sync u_dut (.CLK_IN(clk), .RST_B_IN(rst_b), .WB_CYC_IN(cyc), .WB_STB_IN(cyc),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wd), .WB_DAT_OUT(rd),
		.WB_ACK_OUT(ack), .SINGLE_ENDED_SYNC_REQUEST_B_IN(se_b),
		.TIMESTAMP_DIFFERENTIAL_INPUT_IN(ts), .SYSREF_IN(sr), .SYSREF_RECEIVER_ENABLE_OUT(en_o),
		.SYSREF_DC_TERMINATION_SELECT_OUT(term_o), .CGS_START_OUT(cgs_s),
		.ILAS_START_OUT(ilas_s), .CGS_ACTIVE_OUT(cgs_a), .SYSREF_REF_OUT(ref_o));
	task automatic chk(input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wrap_up;
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// One classic cycle, held until ack
	task automatic bus(input logic w, input logic [3:0] a, s, input logic [31:0] d);
		cyc <= 1;
		we <= w;
		adr <= a;
		sel <= s;
		wd <= d;
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 0;
		@(posedge clk);
	endtask
	task automatic rdx(input logic [3:0] a, input logic [31:0] m, e);
		q.push_back({m, e});
		bus(1'b0, a, 4'hF, 32'h0);
	endtask
	// Timeout, and compare each read at its ack
	always @(posedge clk) begin
		ticks++;
		if (cgs_s === 1'b1) n_cgs++;
		if (ilas_s === 1'b1) n_ilas++;
		if (ticks == 3000) begin
			fails++;
			wrap_up();
		end
		if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
			chk(rd & q[0][63:32], q[0][31:0]);
			void'(q.pop_front());
		end
	end
	initial begin
		v = $urandom(32'hBB36);
		repeat (8) @(posedge clk);
		rst_b <= 1;
		repeat (4) @(posedge clk);
		rdx(4'h0, 32'hFFFFFFFF, 32'h0);
		rdx(4'h4, 32'h3F, 32'h11);
		// All enable and termination values
		for (int i = 0; i < 4; i++) begin
			v = ($urandom & 32'hFFFFFFF0) | (i << 2);
			bus(1'b1, 4'h0, 4'hF, v);
			rdx(4'h0, 32'hF, v & 32'hC);
			chk({30'h0, term_o, en_o}, i);
		end
		bus(1'b1, 4'h0, 4'hE, 32'h0);
		rdx(4'h0, 32'hF, 32'hC);
		chk({30'h0, term_o, en_o}, 32'h3);
		rdx(4'h8, 32'hFFFFFFFF, 32'h0);
		bus(1'b1, 4'h0, 4'hF, 32'h4);
		sr <= 1;
		rs <= 1;
		repeat (8) @(posedge clk);
		rdx(4'h4, 32'h3F, 32'h22);
		chk({31'h0, cgs_a}, 32'h1);
		chk({31'h0, ref_o}, 32'h1);
		chk(n_cgs, 32'h1);
		rs <= 0;
		repeat (8) @(posedge clk);
		rdx(4'h4, 32'h3F, 32'h38);
		chk({31'h0, cgs_a}, 32'h0);
		chk(n_ilas, 32'h1);
		bus(1'b1, 4'h0, 4'hF, 32'h2);
		ts <= 0;
		repeat (8) @(posedge clk);
		rdx(4'h4, 32'h2F, 32'h02);
		chk({31'h0, ref_o}, 32'h0);
		chk(n_cgs, 32'h2);
		ts <= 1;
		rs <= 1;
		repeat (8) @(posedge clk);
		rdx(4'h4, 32'hF, 32'h08);
		chk(n_ilas, 32'h2);
		chk(n_cgs, 32'h2);
		bus(1'b1, 4'h0, 4'hF, 32'h1);
		repeat (8) @(posedge clk);
		rdx(4'h4, 32'hF, 32'h08);
		chk(n_cgs, 32'h2);
		wrap_up();
	end
endmodule // tb_top
